// ---- hw/pll_cfg_pkg.sv ----
package pll_cfg_pkg;

    // Loop configuration byte layout
    localparam int unsigned CFG_W = 8;
    localparam int unsigned CFG_POL = 7;
    localparam int unsigned CFG_DSEL = 6;
    localparam int unsigned CFG_LDE = 5;
    localparam int unsigned CFG_STANDBY_CTL = 4;
    localparam int unsigned CFG_I2 = 3;
    localparam int unsigned CFG_I1 = 2;
    localparam int unsigned CFG_PORT = 1;
    localparam int unsigned CFG_OUTB = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Frame lengths in serial clocks
    localparam int unsigned BITCNT_W = 5;
    localparam logic [4:0] FRAME_CFG = 5'h08;
    localparam logic [4:0] FRAME_R = 5'h10;
    localparam logic [4:0] FRAME_A = 5'h18;
    localparam logic [4:0] BITCNT_MAX = 5'h1F;
    localparam int unsigned SHIFT_W = 24;

    // R frame layout
    localparam int unsigned R_CNT_W = 13;
    localparam int unsigned R_CNT_LSB = 0;
    localparam int unsigned R_OSC_LSB = 13;
    localparam int unsigned R_OSC_W = 3;
    localparam logic [2:0] OSC_MODE_RESET = 3'h0;
    localparam logic [12:0] R_BUF_RESET = 13'h0001;

    // A frame layout
    localparam int unsigned A_SWALLOW_LSB = 0;
    localparam int unsigned A_SWALLOW_W = 6;
    localparam int unsigned A_N_LSB = 6;
    localparam int unsigned A_N_W = 12;
    localparam int unsigned A_OSEL_LSB = 22;
    localparam logic [23:0] A_RESET = 24'hC00040;

    // Multi-function output selection (address bits 23:22)
    localparam logic [1:0] OUTA_PORT = 2'h0;
    localparam logic [1:0] OUTA_REF = 2'h1;
    localparam logic [1:0] OUTA_VCO = 2'h2;
    localparam logic [1:0] OUTA_DATA = 2'h3;

    // Prescaler moduli
    localparam logic [6:0] PSC_DIV_HI = 7'h40;
    localparam logic [6:0] PSC_DIV_LO = 7'h41;

    // Pump current, percent of full scale
    localparam logic [6:0] PCT_25 = 7'h19;
    localparam logic [6:0] PCT_50 = 7'h32;
    localparam logic [6:0] PCT_70 = 7'h46;
    localparam logic [6:0] PCT_75 = 7'h4B;
    localparam logic [6:0] PCT_80 = 7'h50;
    localparam logic [6:0] PCT_90 = 7'h5A;
    localparam logic [6:0] PCT_100 = 7'h64;

    typedef enum logic [1:0] {ST_RUN, ST_STANDBY, ST_RECOVER} pll_state_e;

    function automatic logic [6:0] pump_pct(input logic [1:0] sel,
                                            input logic step25);
        logic [6:0] p;
        case (sel)
            2'h0: p = step25 ? PCT_25 : PCT_70;
            2'h1: p = step25 ? PCT_50 : PCT_80;
            2'h2: p = step25 ? PCT_75 : PCT_90;
            default: p = PCT_100;
        endcase
        return p;
    endfunction : pump_pct

endpackage : pll_cfg_pkg

// ---- hw/pll_config_standby_control.sv ----
// Contract
// RULE1: lock output is AND of both internal phase outputs.
// RULE2: after power-up lock output stays low until enabled.
// RULE3: prescaler divides by 65 while modulus signal low, 64 when high.
// RULE4: host initialises with three 5-bit groups, clock high 100 ns after.
// RULE5: two current bits pick pump current; both high is full scale.
// RULE6: outside port mode, port bit picks 10% or 25% current steps.
// RULE7: in port mode current always uses the 10% step table.
// RULE8: polarity bit inverts pump and swaps phase outputs; resets low.
// RULE9: detector select high uses pump, low uses phase pair; resets low.
// RULE10: lock enable high drives lock output, low forces it low.
// RULE11: standby floats pump, raises phase pair, stops counters and bias.
// RULE12: in standby lock output equals lock enable, statically.
// RULE13: standby keeps A, R and configuration contents.
// RULE14: leaving standby restarts counters and bias, detectors still blocked.
// RULE15: first divided VCO pulse jam-loads R, clears detectors, unblocks.
// RULE16: in port mode the port bit drives the multi-function output.
// RULE17: standby leaves port and open-drain bits and pins alone.
// RULE18: open-drain bit high floats, low pulls low; resets low.
// RULE19: an 8-clock frame writes only the configuration byte.
// RULE20: multi-function output defaults to serial data out.
// RULE21: N not below A; VCO divided by N times 64 plus A.
// RULE22: 24-clock frame loads A and copies first R buffer to second.
// RULE23: address bits both low make output a port driven by port bit.
// RULE24: 16-clock frame updates oscillator mode and first R buffer.
// RULE25: clock count picks destination; other counts are ignored.
`timescale 1ns/1ps
`default_nettype none
module pll_config_standby_control
    import pll_cfg_pkg::*;
#(
    parameter int unsigned RCNT_W = R_CNT_W,
    parameter int unsigned NCNT_W = A_N_W
) (
    input wire logic clk_sys,               // System clock, 100 MHz
    input wire logic rst_n,                 // Async reset, active low
    input wire logic ce,                    // Clock enable
    input wire logic sclk,                  // Serial clock from host
    input wire logic serial_frame_enable_n, // Frame active while low
    input wire logic serial_data_in,        // Serial data
    input wire logic ref_clk_in,            // Reference input
    input wire logic vco_in,                // Divided-down VCO input
    output logic lock_detect_out,           // Lock detector
    output logic ref_phase_out,             // Reference phase, low pulses
    output logic vco_phase_out,             // VCO phase, low pulses
    output logic pump_output_o,             // 1 sources, 0 sinks
    output logic pump_output_oe,            // Pump driven when high
    output logic [6:0] pump_current_pct,    // Pump current percent
    output logic bias_enable,               // Bias current on
    output logic modulus_control_test,      // Prescaler modulus
    output logic multi_function_output,     // Push-pull general output
    output logic open_drain_output_o,       // Open-drain level
    output logic open_drain_output_oe,      // Open-drain pulling low
    output logic [2:0] osc_mode             // Oscillator mode bits
);
    logic [SHIFT_W-1:0] shift_data;
    logic bit_toggle, data_out;
    logic enb_s, enb_d, enb_e, tgl_s, tgl_d, ref_s, ref_d, vco_s, vco_d;
    logic frame_start, frame_end, bit_pulse, ref_tick, vco_tick;
    logic [BITCNT_W-1:0] bit_cnt;
    logic [CFG_W-1:0] cfg;
    logic [RCNT_W-1:0] r_buf1, r_buf2, r_cnt;
    logic [SHIFT_W-1:0] a_reg;
    pll_state_e state;
    logic count_en, det_en, standby_ctl_now, port_mode;
    logic [6:0] psc_cnt;
    logic [NCNT_W-1:0] n_cnt;
    logic [A_SWALLOW_W-1:0] a_cnt;
    logic psc_wrap, fr_pulse, fv_pulse, pfd_up, pfd_dn;
    logic phi_r_int, phi_v_int, src, snk;
    logic [1:0] cur_sel;

    serial_shift u_shift (
        .sclk(sclk),
        .rst_n(rst_n),
        .serial_frame_enable_n(serial_frame_enable_n),
        .serial_data_in(serial_data_in),
        .shift_data(shift_data),
        .bit_toggle(bit_toggle),
        .data_out(data_out)
    );

    // Synchronised as frame-active so the reset level of the flops is idle
    sync2 u_enb (.clk(clk_sys), .rst_n(rst_n), .ce(ce),
                 .d(~serial_frame_enable_n), .q(enb_s));
    sync2 u_tgl (.clk(clk_sys), .rst_n(rst_n), .ce(ce),
                 .d(bit_toggle), .q(tgl_s));
    sync2 u_ref (.clk(clk_sys), .rst_n(rst_n), .ce(ce),
                 .d(ref_clk_in), .q(ref_s));
    sync2 u_vco (.clk(clk_sys), .rst_n(rst_n), .ce(ce),
                 .d(vco_in), .q(vco_s));

    // Frame end is seen one stage late so the last bit toggle lands first
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enb_d <= 1'b0;
            enb_e <= 1'b0;
            tgl_d <= 1'b0;
            ref_d <= 1'b0;
            vco_d <= 1'b0;
        end else if (ce) begin
            enb_d <= enb_s;
            enb_e <= enb_d;
            tgl_d <= tgl_s;
            ref_d <= ref_s;
            vco_d <= vco_s;
        end
    end

    assign frame_start = enb_s & ~enb_d;
    assign frame_end = enb_e & ~enb_d;
    assign bit_pulse = tgl_s ^ tgl_d;
    assign ref_tick = ref_s & ~ref_d;
    assign vco_tick = vco_s & ~vco_d;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= '0;
        end else if (ce) begin
            if (frame_start) begin
                bit_cnt <= {4'h0, bit_pulse};
            end else if (bit_pulse && bit_cnt != BITCNT_MAX) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // Shift data is quiet once the frame has closed, so it is read as is
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_RESET; // RULE2 RULE8 RULE9 RULE10 RULE18
            r_buf1 <= R_BUF_RESET;
            r_buf2 <= R_BUF_RESET;
            a_reg <= A_RESET; // RULE20
            osc_mode <= OSC_MODE_RESET;
        end else if (ce && frame_end) begin
            case (bit_cnt) // RULE25
                FRAME_CFG: cfg <= shift_data[CFG_W-1:0]; // RULE19
                FRAME_R: begin // RULE24
                    osc_mode <= shift_data[R_OSC_LSB +: R_OSC_W];
                    r_buf1 <= shift_data[R_CNT_LSB +: RCNT_W];
                end
                FRAME_A: begin // RULE22
                    a_reg <= shift_data;
                    r_buf2 <= r_buf1;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RUN;
        end else if (ce) begin
            case (state)
                ST_RUN: if (cfg[CFG_STANDBY_CTL]) state <= ST_STANDBY;
                ST_STANDBY: if (!cfg[CFG_STANDBY_CTL]) state <= ST_RECOVER; // RULE14
                ST_RECOVER: begin
                    if (cfg[CFG_STANDBY_CTL]) begin
                        state <= ST_STANDBY;
                    end else if (fv_pulse) begin
                        state <= ST_RUN; // RULE15
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    assign standby_ctl_now = (state == ST_STANDBY);
    assign count_en = !standby_ctl_now; // RULE11 RULE14
    assign det_en = (state == ST_RUN); // RULE14
    assign bias_enable = count_en; // RULE11
    assign port_mode = (a_reg[A_OSEL_LSB +: 2] == OUTA_PORT); // RULE23

    // Swallow counter holds the low modulus for the first A cycles
    assign modulus_control_test = (a_cnt == '0); // RULE3
    assign psc_wrap = ce && count_en && vco_tick &&
        psc_cnt == (modulus_control_test ? PSC_DIV_HI : PSC_DIV_LO) - 7'h01;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            psc_cnt <= '0;
        end else if (ce && count_en && vco_tick) begin
            psc_cnt <= psc_wrap ? 7'h00 : psc_cnt + 7'h01; // RULE3
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            n_cnt <= '0;
            a_cnt <= '0;
            fv_pulse <= 1'b0;
        end else if (ce) begin
            fv_pulse <= 1'b0;
            if (psc_wrap) begin
                if (n_cnt <= 1) begin // RULE21
                    n_cnt <= a_reg[A_N_LSB +: NCNT_W];
                    a_cnt <= a_reg[A_SWALLOW_LSB +: A_SWALLOW_W];
                    fv_pulse <= 1'b1;
                end else begin
                    n_cnt <= n_cnt - 1'b1;
                    if (a_cnt != '0) begin
                        a_cnt <= a_cnt - 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r_cnt <= '0;
            fr_pulse <= 1'b0;
        end else if (ce) begin
            fr_pulse <= 1'b0;
            if (state == ST_RECOVER && fv_pulse) begin
                r_cnt <= r_buf2; // RULE15
            end else if (count_en && ref_tick) begin // RULE11
                if (r_cnt <= 1) begin
                    r_cnt <= r_buf2;
                    fr_pulse <= 1'b1;
                end else begin
                    r_cnt <= r_cnt - 1'b1;
                end
            end
        end
    end

    // Both flags set clears both next cycle: the short in-phase pulse
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pfd_up <= 1'b0;
            pfd_dn <= 1'b0;
        end else if (ce) begin
            if (!det_en || (pfd_up && pfd_dn)) begin // RULE14 RULE15
                pfd_up <= 1'b0;
                pfd_dn <= 1'b0;
            end else begin
                if (fr_pulse) pfd_up <= 1'b1;
                if (fv_pulse) pfd_dn <= 1'b1;
            end
        end
    end

    assign phi_r_int = ~(cfg[CFG_POL] ? pfd_dn : pfd_up); // RULE8
    assign phi_v_int = ~(cfg[CFG_POL] ? pfd_up : pfd_dn); // RULE8
    assign src = cfg[CFG_POL] ? pfd_dn : pfd_up; // RULE8
    assign snk = cfg[CFG_POL] ? pfd_up : pfd_dn;
    assign cur_sel = {cfg[CFG_I2], cfg[CFG_I1]};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_detect_out <= 1'b0;
            ref_phase_out <= 1'b1;
            vco_phase_out <= 1'b1;
            pump_output_o <= 1'b0;
            pump_output_oe <= 1'b0;
            pump_current_pct <= PCT_70;
        end else if (ce) begin
            if (!cfg[CFG_LDE]) begin
                lock_detect_out <= 1'b0; // RULE10
            end else if (standby_ctl_now) begin
                lock_detect_out <= 1'b1; // RULE12
            end else begin
                lock_detect_out <= phi_r_int & phi_v_int; // RULE1
            end
            ref_phase_out <= cfg[CFG_DSEL] | standby_ctl_now | phi_r_int; // RULE9
            vco_phase_out <= cfg[CFG_DSEL] | standby_ctl_now | phi_v_int; // RULE11
            pump_output_o <= src;
            pump_output_oe <= cfg[CFG_DSEL] && !standby_ctl_now && (src ^ snk);
            pump_current_pct <= pump_pct(cur_sel, // RULE5
                cfg[CFG_PORT] & ~port_mode); // RULE6 RULE7
        end
    end

    // Port and open-drain pins ignore standby by construction
    always_comb begin
        case (a_reg[A_OSEL_LSB +: 2])
            OUTA_PORT: multi_function_output = cfg[CFG_PORT]; // RULE16 RULE17
            OUTA_REF: multi_function_output = fr_pulse;
            OUTA_VCO: multi_function_output = fv_pulse;
            default: multi_function_output = data_out; // RULE20
        endcase
    end

    assign open_drain_output_o = 1'b0;
    assign open_drain_output_oe = ~cfg[CFG_OUTB]; // RULE18 RULE17

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_ld_and;
        ce && cfg[CFG_LDE] && !standby_ctl_now
            |=> lock_detect_out == $past(phi_r_int & phi_v_int);
    endproperty
    a_ld_and: assert property (p_ld_and) // RULE1
        else $error("lock output is not AND of phases");

    property p_ld_off;
        ce && !cfg[CFG_LDE] |=> !lock_detect_out;
    endproperty
    a_ld_off: assert property (p_ld_off) // RULE10
        else $error("lock output high while disabled");

    property p_ld_standby_ctl;
        ce && standby_ctl_now && cfg[CFG_LDE] |=> lock_detect_out;
    endproperty
    a_ld_standby_ctl: assert property (p_ld_standby_ctl) // RULE12
        else $error("lock output not high in standby");

    property p_psc;
        psc_wrap |-> psc_cnt ==
            (modulus_control_test ? 7'h3F : 7'h40);
    endproperty
    a_psc: assert property (p_psc) // RULE3
        else $error("prescaler modulus wrong");

    property p_pump_float;
        ce && (!cfg[CFG_DSEL] || standby_ctl_now) |=> !pump_output_oe;
    endproperty
    a_pump_float: assert property (p_pump_float) // RULE9
        else $error("pump driven while disabled");

    property p_phase_rest;
        ce && (cfg[CFG_DSEL] || standby_ctl_now)
            |=> ref_phase_out && vco_phase_out;
    endproperty
    a_phase_rest: assert property (p_phase_rest) // RULE11
        else $error("phase outputs not at rest");

    property p_count_stop;
        standby_ctl_now |=> $stable(r_cnt) && $stable(n_cnt) && $stable(psc_cnt);
    endproperty
    a_count_stop: assert property (p_count_stop) // RULE11
        else $error("counter moved in standby");

    property p_block;
        state == ST_RECOVER |=> !pfd_up && !pfd_dn;
    endproperty
    a_block: assert property (p_block) // RULE14
        else $error("detector not blocked in recovery");

    property p_jam;
        ce && state == ST_RECOVER && fv_pulse && !cfg[CFG_STANDBY_CTL]
            |=> state == ST_RUN && r_cnt == $past(r_buf2);
    endproperty
    a_jam: assert property (p_jam) // RULE15
        else $error("no jam load on first VCO pulse");

    property p_cfg_write;
        ce && frame_end && bit_cnt == FRAME_CFG
            |=> cfg == $past(shift_data[CFG_W-1:0]) && $stable(a_reg);
    endproperty
    a_cfg_write: assert property (p_cfg_write) // RULE19
        else $error("configuration frame mishandled");

    property p_a_write;
        ce && frame_end && bit_cnt == FRAME_A
            |=> r_buf2 == $past(r_buf1) && $stable(cfg);
    endproperty
    a_a_write: assert property (p_a_write) // RULE22
        else $error("A frame did not copy R buffer");

    property p_pct_port;
        ce && port_mode |=> pump_current_pct == $past(pump_pct(cur_sel, 1'b0));
    endproperty
    a_pct_port: assert property (p_pct_port) // RULE7
        else $error("port mode not on 10 percent table");

    property p_port;
        port_mode |-> multi_function_output == cfg[CFG_PORT];
    endproperty
    a_port: assert property (p_port) // RULE16
        else $error("port pin differs from port bit");

    c_cfg: cover property (ce && frame_end && bit_cnt == FRAME_CFG);
    c_afrm: cover property (ce && frame_end && bit_cnt == FRAME_A);
    c_recover: cover property (state == ST_RECOVER ##1 state == ST_RUN);
endmodule : pll_config_standby_control
`default_nettype wire

// ---- hw/serial_shift.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_shift
    import pll_cfg_pkg::*;
(
    input wire logic sclk,                  // Serial clock from host
    input wire logic rst_n,                 // Async reset, active low
    input wire logic serial_frame_enable_n, // Frame active while low
    input wire logic serial_data_in,        // Serial data, MSB first
    output logic [SHIFT_W-1:0] shift_data,  // Last bits received
    output logic bit_toggle,                // Flips on every bit taken
    output logic data_out                   // Cascade data out
);
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_data <= '0;
            bit_toggle <= 1'b0;
        end else if (!serial_frame_enable_n) begin
            shift_data <= {shift_data[SHIFT_W-2:0], serial_data_in};
            bit_toggle <= ~bit_toggle;
        end
    end

    // Changes on the falling edge so a cascaded part samples it cleanly
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 1'b0;
        end else begin
            data_out <= shift_data[SHIFT_W-1];
        end
    end
endmodule : serial_shift
`default_nettype wire

// ---- hw/sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    input wire logic clk,   // Destination clock
    input wire logic rst_n, // Async reset, active low
    input wire logic ce,    // Clock enable
    input wire logic d,     // Asynchronous level
    output logic q          // Synchronised level
);
    logic meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : sync2
`default_nettype wire

// ---- tb/pll_config_standby_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll_config_standby_control_tb
    import pll_cfg_pkg::*;
;
    logic clk_sys, rst_n, ce, ref_clk_in, vco_in, run_clocks;
    logic sclk, serial_frame_enable_n, serial_data_in;
    logic lock_detect_out, ref_phase_out, vco_phase_out;
    logic pump_output_o, pump_output_oe, bias_enable, modulus_control_test;
    logic multi_function_output, open_drain_output_o, open_drain_output_oe;
    logic [6:0] pump_current_pct;
    logic [2:0] osc_mode;
    logic [7:0] cyc;
    int failures = 0;
    int checks = 0;

    pll_config_standby_control pll_config_standby_control_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .sclk(sclk),
        .serial_frame_enable_n(serial_frame_enable_n),
        .serial_data_in(serial_data_in), .ref_clk_in(ref_clk_in),
        .vco_in(vco_in), .lock_detect_out(lock_detect_out),
        .ref_phase_out(ref_phase_out), .vco_phase_out(vco_phase_out),
        .pump_output_o(pump_output_o), .pump_output_oe(pump_output_oe),
        .pump_current_pct(pump_current_pct), .bias_enable(bias_enable),
        .modulus_control_test(modulus_control_test),
        .multi_function_output(multi_function_output),
        .open_drain_output_o(open_drain_output_o),
        .open_drain_output_oe(open_drain_output_oe), .osc_mode(osc_mode));

    pll_host_model pll_host_model_inst (
        .sclk(sclk), .serial_frame_enable_n(serial_frame_enable_n),
        .serial_data_in(serial_data_in));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Free-running inputs: fV ticks 64 times per fR tick
    always @(negedge clk_sys) begin
        if (run_clocks) begin
            cyc <= cyc + 8'h01;
            vco_in <= cyc[1];
            ref_clk_in <= cyc[7];
        end
    end

    task automatic close_out();
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [6:0] seen,
                         input logic [6:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_clk

    task automatic cfg(input logic [7:0] v);
        pll_host_model_inst.send({16'h0000, v}, 8, 1'b0);
        wait_clk(10);
    endtask : cfg

    task automatic t_reset();
        check("lock", 7'(lock_detect_out), 7'h00);
        check("pct", pump_current_pct, PCT_70);
        check("od_oe", 7'(open_drain_output_oe), 7'h01);
        check("pump_oe", 7'(pump_output_oe), 7'h00);
        check("phases", 7'({ref_phase_out, vco_phase_out}), 7'h03);
        // Three 5-bit groups with the clock held high are not a frame
        repeat (3) pll_host_model_inst.send(24'h00001F, 5, 1'b1);
        wait_clk(10);
        check("pct", pump_current_pct, PCT_70);
        check("osc", 7'(osc_mode), 7'h00);
    endtask : t_reset

    task automatic t_pct();
        logic [6:0] tbl [8] = '{PCT_70, PCT_25, PCT_80, PCT_50,
                                PCT_90, PCT_75, PCT_100, PCT_100};
        for (int i = 0; i < 8; i++) begin
            cfg(8'(i << 1));
            check("pct", pump_current_pct, tbl[i]);
        end
        pll_host_model_inst.send(24'h00A001, 16, 1'b0);
        wait_clk(10);
        check("osc", 7'(osc_mode), 7'h05);
        check("pct", pump_current_pct, PCT_100);
        cfg(8'h06);
        check("osc", 7'(osc_mode), 7'h05);
    endtask : t_pct

    task automatic t_phase();
        cfg(8'h20);
        repeat (2) begin
            ref_clk_in = 1'b1;
            wait_clk(4);
            ref_clk_in = 1'b0;
            wait_clk(4);
        end
        check("phases", 7'({ref_phase_out, vco_phase_out}), 7'h01);
        check("lock", 7'(lock_detect_out), 7'h00);
        cfg(8'hA0);
        check("phases", 7'({ref_phase_out, vco_phase_out}), 7'h02);
        cfg(8'h40);
        check("pump", 7'({pump_output_oe, pump_output_o}), 7'h03);
        check("phases", 7'({ref_phase_out, vco_phase_out}), 7'h03);
        cfg(8'hC0);
        check("pump", 7'({pump_output_oe, pump_output_o}), 7'h02);
    endtask : t_phase

    task automatic t_standby();
        cfg(8'h11);
        check("bias", 7'(bias_enable), 7'h00);
        check("pump_oe", 7'(pump_output_oe), 7'h00);
        check("phases", 7'({ref_phase_out, vco_phase_out}), 7'h03);
        check("lock", 7'(lock_detect_out), 7'h00);
        check("od_oe", 7'(open_drain_output_oe), 7'h00);
        check("osc", 7'(osc_mode), 7'h05);
        cfg(8'h31);
        check("lock", 7'(lock_detect_out), 7'h01);
        cfg(8'h21);
        check("bias", 7'(bias_enable), 7'h01);
        check("od_oe", 7'(open_drain_output_oe), 7'h00);
    endtask : t_standby

    task automatic t_lock();
        run_clocks = 1'b1;
        wait_clk(600);
        for (int i = 0; i < 1024; i++) begin
            check("lock", 7'(lock_detect_out),
                  7'(ref_phase_out & vco_phase_out));
            wait_clk(1);
        end
        cfg(8'h01);
        check("lock", 7'(lock_detect_out), 7'h00);
        run_clocks = 1'b0;
    endtask : t_lock

    task automatic t_port();
        cfg(8'h06);
        // Port select, N = 1 not below A = 0
        pll_host_model_inst.send(24'h000040, 24, 1'b0);
        wait_clk(10);
        check("mfo", 7'(multi_function_output), 7'h01);
        check("pct", pump_current_pct, PCT_80);
        cfg(8'h12);
        check("mfo", 7'(multi_function_output), 7'h01);
        cfg(8'h00);
        check("mfo", 7'(multi_function_output), 7'h00);
    endtask : t_port

    initial begin
        #500000;
        failures++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        ref_clk_in = 1'b0;
        vco_in = 1'b0;
        run_clocks = 1'b0;
        cyc = 8'h00;
        wait_clk(5);
        rst_n = 1'b1;
        wait_clk(2);
        t_reset();
        t_pct();
        t_phase();
        t_standby();
        t_lock();
        t_port();
        close_out();
    end
endmodule : pll_config_standby_control_tb
`default_nettype wire

// ---- tb/pll_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll_host_model (
    output logic sclk,                  // Serial clock, no rising edge between frames
    output logic serial_frame_enable_n, // Frame strobe, active low
    output logic serial_data_in         // Serial data, MSB first
);
    initial begin
        sclk = 1'b0;
        serial_frame_enable_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // Shifts the n low bits of d, MSB first, 80 ns per bit
    task automatic send(input logic [23:0] d, input int n, input logic hold);
        serial_frame_enable_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in = d[i];
            #40 sclk = 1'b1;
            #40 if (!hold || i > 0) sclk = 1'b0;
        end
        #20 serial_frame_enable_n = 1'b1;
        // Released line must not keep showing the last bit
        serial_data_in = ~serial_data_in;
        if (hold) #120 sclk = 1'b0;
        #40;
    endtask : send
endmodule : pll_host_model
`default_nettype wire
